// ===== src/dcc_top.sv
// Four-channel DMA count and control with transfer sequencing
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [1:0]  transfer_request_in_b,
    input  wire logic [3:0]  periph_req,
    input  wire logic        nmi_in,
    input  wire logic        standby_in,
    output logic      [1:0]  request_acknowledge_out,
    output logic      [1:0]  transfer_acknowledge_out,
    output logic      [3:0]  end_irq,
    output logic             xfer_rd,
    output logic             xfer_wr,
    output logic      [1:0]  xfer_chan,
    output logic      [1:0]  xfer_size,
    output logic      [3:0]  src_step,
    output logic      [3:0]  dst_step,
    output logic             src_indirect,
    output logic             src_reload
);
    logic [31:0]          ctrl_w [DCC_NCH];
    logic [DCC_CNT_W-1:0] cnt_r  [DCC_NCH];
    logic [3:0]           run_vec;
    logic [3:0]           rdy_vec;
    logic [3:0]           te_set_vec;
    logic [3:0]           ext_req_vec;
    logic [1:0]           ext_lvl_b;
    logic [1:0]           ext_prev_r;
    logic [1:0]           pend_r;
    logic [1:0]           rak_r;
    logic                 nmi_lvl;
    logic                 nmi_prev_r;
    logic                 stby_lvl;
    logic                 gen_r;
    logic                 nmi_seen_flag_r;
    logic                 nmi_seen_flag_seen_r;
    dcc_state_t           st_r;
    dcc_state_t           st_nxt;
    logic [1:0]           chan_r;
    logic [1:0]           grant;
    logic                 grant_ok;
    logic                 is_ctrl;
    logic                 is_cnt;
    logic                 is_glb;
    logic [1:0]           sel;
    logic [DCC_CNT_W-1:0] cur_cnt;
    logic                 dec;
    logic [31:0]          rdata_nxt;

    dcc_sync #(.W(2), .RST_VAL(32'h0000_0003)) u_sync_req (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (transfer_request_in_b),
        .q     (ext_lvl_b)
    );

    dcc_sync #(.W(2), .RST_VAL(32'h0000_0000)) u_sync_sys (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({standby_in, nmi_in}),
        .q     ({stby_lvl, nmi_lvl})
    );

    // Channel n control at 0x10*n, its count at 0x10*n+4
    assign sel     = reg_addr[5:4];
    assign is_ctrl = (reg_addr[7:6] == 2'h0) && (reg_addr[3:0] == DCC_CTRL_OFS[3:0]);
    assign is_cnt  = (reg_addr[7:6] == 2'h0) && (reg_addr[3:0] == DCC_CNT_OFS[3:0]);
    assign is_glb  = (reg_addr == DCC_GLOBAL_OFS);
    assign cur_cnt = cnt_r[chan_r];
    assign dec     = (st_r == DCC_ST_WR);

    function automatic logic [3:0] step_of(input logic [1:0] mode, input logic [3:0] mag);
        logic [3:0] s;
        s = 4'h0;
        if (mode == DCC_MODE_INC)
            s = mag;
        else if (mode == DCC_MODE_DEC)
            s = 4'h0 - mag;
        return s;
    endfunction

    genvar c;
    for (c = 0; c < DCC_NCH; c++)
    begin : g_ch
        logic [3:0] rs;
        logic [1:0] ts;
        logic       legal;

        dcc_chan_reg #(.CH(c)) u_reg (
            .clk    (clk),
            .rst_b  (rst_b),
            .clear  (stby_lvl),
            .wr     (reg_wr && is_ctrl && (sel == 2'(c))),
            .rd     (reg_rd && is_ctrl && (sel == 2'(c))),
            .wdata  (reg_wdata),
            .te_set (te_set_vec[c]),
            .ctrl   (ctrl_w[c])
        );

        assign rs = ctrl_w[c][DCC_B_RS+3:DCC_B_RS];
        assign ts = ctrl_w[c][DCC_B_TS+1:DCC_B_TS];
        // Illegal codes simply keep the channel idle
        assign legal = (ts != DCC_ILLEGAL)
                    && (ctrl_w[c][DCC_B_SM+1:DCC_B_SM] != DCC_ILLEGAL)
                    && (ctrl_w[c][DCC_B_DM+1:DCC_B_DM] != DCC_ILLEGAL)
                    && ((rs == DCC_RS_AUTO) || (rs >= DCC_RS_PERIPH)
                        || ((rs == DCC_RS_EXT) && (c < 2)));
        assign run_vec[c] = ctrl_w[c][DCC_B_DE] && !ctrl_w[c][DCC_B_TE]
                         && gen_r && !nmi_seen_flag_r && legal && !stby_lvl;
        assign rdy_vec[c] = run_vec[c] && ((rs == DCC_RS_AUTO) ? 1'b1 :
                            (rs == DCC_RS_EXT) ? ext_req_vec[c] : periph_req[c]);
        assign te_set_vec[c] = dec && (chan_r == 2'(c)) && (cnt_r[c] == DCC_CNT_ONE);
        assign end_irq[c] = ctrl_w[c][DCC_B_TE] && ctrl_w[c][DCC_B_IE];

        if (c < 2)
        begin : g_ext
            // Sense select picks low level or latched falling edge
            assign ext_req_vec[c] = ctrl_w[c][DCC_B_DS] ? pend_r[c] : !ext_lvl_b[c];
            assign request_acknowledge_out[c] = ~(rak_r[c] ^ ctrl_w[c][DCC_B_RL]);
            assign transfer_acknowledge_out[c] =
                ~(((chan_r == 2'(c)) && (ctrl_w[c][DCC_B_AM] ? (st_r == DCC_ST_WR)
                                                            : (st_r == DCC_ST_RD)))
                  ^ ctrl_w[c][DCC_B_AL]);
        end
        else
        begin : g_noext
            assign ext_req_vec[c] = 1'b0;
        end
    end

    always_comb
    begin
        grant    = 2'h0;
        grant_ok = 1'b0;
        for (int i = DCC_NCH - 1; i >= 0; i--)
        begin
            if (rdy_vec[i])
            begin
                grant    = 2'(i);
                grant_ok = 1'b1;
            end
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            DCC_ST_IDLE:
                if (grant_ok)
                    st_nxt = DCC_ST_RD;
            DCC_ST_RD:
                st_nxt = DCC_ST_WR;
            DCC_ST_WR:
                // Burst keeps the channel; cycle steal gives it back
                if (ctrl_w[chan_r][DCC_B_TM] && run_vec[chan_r] && (cur_cnt != DCC_CNT_ONE))
                    st_nxt = DCC_ST_RD;
                else
                    st_nxt = DCC_ST_IDLE;
            default:
                st_nxt = DCC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= DCC_ST_IDLE;
        else if (stby_lvl)
            st_r <= DCC_ST_IDLE;
        else
            st_r <= st_nxt;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chan_r       <= 2'h0;
            xfer_size    <= DCC_SZ_8;
            src_step     <= 4'h0;
            dst_step     <= 4'h0;
            src_indirect <= 1'b0;
        end
        else if (st_r == DCC_ST_IDLE && grant_ok)
        begin
            logic [3:0] mag;
            logic       ind;
            mag = (ctrl_w[grant][DCC_B_TS+1:DCC_B_TS] == DCC_SZ_8)  ? 4'h1 :
                  (ctrl_w[grant][DCC_B_TS+1:DCC_B_TS] == DCC_SZ_16) ? 4'h2 : 4'h4;
            ind = ctrl_w[grant][DCC_B_DI];
            chan_r       <= grant;
            xfer_size    <= ctrl_w[grant][DCC_B_TS+1:DCC_B_TS];
            src_indirect <= ind;
            src_step     <= step_of(ctrl_w[grant][DCC_B_SM+1:DCC_B_SM],
                                    ind ? DCC_STEP_IND : mag);
            dst_step     <= step_of(ctrl_w[grant][DCC_B_DM+1:DCC_B_DM], mag);
        end
    end

    assign xfer_rd   = (st_r == DCC_ST_RD);
    assign xfer_wr   = (st_r == DCC_ST_WR);
    assign xfer_chan = chan_r;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rak_r      <= 2'h0;
            src_reload <= 1'b0;
        end
        else
        begin
            rak_r[0]   <= (st_r == DCC_ST_IDLE) && grant_ok && (grant == 2'h0);
            rak_r[1]   <= (st_r == DCC_ST_IDLE) && grant_ok && (grant == 2'h1);
            src_reload <= te_set_vec[2] && ctrl_w[2][DCC_B_RO];
        end
    end

    // Edge pending flags; a new edge wins over the grant that clears
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_prev_r <= 2'h3;
            pend_r     <= 2'h0;
        end
        else
        begin
            ext_prev_r <= ext_lvl_b;
            for (int i = 0; i < 2; i++)
            begin
                // Edges seen in level mode must not start a later edge-mode run
                if (ext_prev_r[i] && !ext_lvl_b[i] && ctrl_w[i][DCC_B_DS])
                    pend_r[i] <= 1'b1;
                else if ((st_r == DCC_ST_IDLE) && grant_ok && (grant == 2'(i)))
                    pend_r[i] <= 1'b0;
            end
        end
    end

    // Counts are undefined after reset; zero is a convenient start
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < DCC_NCH; i++)
                cnt_r[i] <= DCC_CNT_RST;
        end
        else
        begin
            for (int i = 0; i < DCC_NCH; i++)
            begin
                if (reg_wr && is_cnt && (sel == 2'(i)))
                    cnt_r[i] <= reg_wdata[DCC_CNT_W-1:0];
                else if (dec && (chan_r == 2'(i)))
                    cnt_r[i] <= cnt_r[i] - DCC_CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gen_r       <= 1'b0;
            nmi_seen_flag_r      <= 1'b0;
            nmi_seen_flag_seen_r <= 1'b0;
            nmi_prev_r  <= 1'b0;
        end
        else
        begin
            nmi_prev_r <= nmi_lvl;
            if (stby_lvl)
                gen_r <= 1'b0;
            else if (reg_wr && is_glb)
                gen_r <= reg_wdata[DCC_G_EN];
            if (stby_lvl)
                nmi_seen_flag_r <= 1'b0;
            else if (nmi_lvl && !nmi_prev_r)
                nmi_seen_flag_r <= 1'b1;
            else if (reg_wr && is_glb && !reg_wdata[DCC_G_NMI] && nmi_seen_flag_seen_r)
                nmi_seen_flag_r <= 1'b0;
            if (!nmi_seen_flag_r || stby_lvl)
                nmi_seen_flag_seen_r <= 1'b0;
            else if (reg_rd && is_glb)
                nmi_seen_flag_seen_r <= 1'b1;
        end
    end

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (is_ctrl)
            rdata_nxt = ctrl_w[sel];
        else if (is_cnt)
            rdata_nxt = {8'h00, cnt_r[sel]};
        else if (is_glb)
            rdata_nxt = {30'h0, nmi_seen_flag_r, gen_r};
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= 32'h0000_0000;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    count_dec_a: assert property ((st_r == DCC_ST_WR) && !reg_wr |=>
        cnt_r[$past(chan_r)] == $past(cur_cnt) - DCC_CNT_ONE)
        else $error("count did not step down after a unit");
    count_max_a: assert property ((st_r == DCC_ST_WR) && !reg_wr && (cur_cnt == 24'h0) |=>
        (cnt_r[$past(chan_r)] == 24'hff_ffff) && !ctrl_w[$past(chan_r)][DCC_B_TE])
        else $error("zero count did not act as maximum");
    end_flag_a: assert property ((st_r == DCC_ST_WR) && (cur_cnt == DCC_CNT_ONE) && !stby_lvl
        |=> ctrl_w[$past(chan_r)][DCC_B_TE] && (st_r == DCC_ST_IDLE))
        else $error("end flag not set at final unit");
    cnt_upper_a: assert property (reg_rd && is_cnt |=> reg_rdata[31:24] == 8'h00)
        else $error("count upper byte not zero");
    ctrl_res_a: assert property (reg_rd && is_ctrl |=>
        (reg_rdata[31:21] == 11'h0) && !reg_rdata[7])
        else $error("reserved control bits not zero");
    chan_mask_a: assert property ((ctrl_w[0][20:19] == 2'h0) && (ctrl_w[2][20] == 1'b0)
        && (ctrl_w[3][19:16] == 4'h0) && !ctrl_w[3][6] && (ctrl_w[2][18:16] == 3'h0))
        else $error("unimplemented channel bit holds a one");
    stby_clear_a: assert property (stby_lvl |=> (ctrl_w[0] == 32'h0) && (ctrl_w[3] == 32'h0)
        && (st_r == DCC_ST_IDLE))
        else $error("standby did not clear control");
    grant_run_a: assert property ((st_r == DCC_ST_IDLE) ##1 (st_r == DCC_ST_RD) |->
        $past(run_vec[grant]) && !$past(nmi_seen_flag_r) && $past(gen_r))
        else $error("channel started while blocked");
    ind_step_a: assert property ((st_r == DCC_ST_IDLE) && grant_ok && (grant == 2'h3)
        && ctrl_w[3][DCC_B_DI] && (ctrl_w[3][13:12] == DCC_MODE_DEC)
        |=> src_step == 4'hc)
        else $error("indirect step not minus four");
    ack_time_a: assert property ((st_r == DCC_ST_RD) && (chan_r == 2'h0) && !stby_lvl
        ##1 (st_r == DCC_ST_WR) |-> (transfer_acknowledge_out[0] == ctrl_w[0][DCC_B_AL])
        == ctrl_w[0][DCC_B_AM])
        else $error("transfer acknowledge in wrong cycle");

    burst_c: cover property ((st_r == DCC_ST_WR) ##1 (st_r == DCC_ST_RD));
    end_c: cover property (te_set_vec[0] ##1 end_irq[0]);
    ind_c: cover property (xfer_rd && src_indirect);
    edge_c: cover property (pend_r[1] ##[1:8] rak_r[1]);
endmodule
`default_nettype wire

// ===== src/dcc_pkg.sv
// Constants and types for the DMA channel count and control block
package dcc_pkg;
    localparam int          DCC_NCH        = 4;
    localparam int          DCC_CNT_W      = 24;
    localparam logic [7:0]  DCC_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  DCC_CNT_OFS    = 8'h04;
    localparam logic [7:0]  DCC_GLOBAL_OFS = 8'h40;
    localparam logic [31:0] DCC_CTRL_RST   = 32'h0000_0000;
    localparam logic [23:0] DCC_CNT_ONE    = 24'h00_0001;
    localparam logic [23:0] DCC_CNT_RST    = 24'h00_0000;
    localparam logic [31:0] DCC_MASK_ALL   = 32'h0000_ff3f;
    localparam logic [31:0] DCC_MASK_CH01  = 32'h0007_0040;
    localparam logic [31:0] DCC_MASK_CH2   = 32'h0008_0000;
    localparam logic [31:0] DCC_MASK_CH3   = 32'h0010_0000;
    localparam int          DCC_B_DE       = 0;
    localparam int          DCC_B_TE       = 1;
    localparam int          DCC_B_IE       = 2;
    localparam int          DCC_B_TS       = 3;
    localparam int          DCC_B_TM       = 5;
    localparam int          DCC_B_DS       = 6;
    localparam int          DCC_B_RS       = 8;
    localparam int          DCC_B_SM       = 12;
    localparam int          DCC_B_DM       = 14;
    localparam int          DCC_B_AL       = 16;
    localparam int          DCC_B_AM       = 17;
    localparam int          DCC_B_RL       = 18;
    localparam int          DCC_B_RO       = 19;
    localparam int          DCC_B_DI       = 20;
    localparam int          DCC_G_EN       = 0;
    localparam int          DCC_G_NMI      = 1;
    localparam logic [3:0]  DCC_RS_EXT     = 4'h0;
    localparam logic [3:0]  DCC_RS_AUTO    = 4'h4;
    localparam logic [3:0]  DCC_RS_PERIPH  = 4'ha;
    localparam logic [1:0]  DCC_MODE_FIX   = 2'h0;
    localparam logic [1:0]  DCC_MODE_INC   = 2'h1;
    localparam logic [1:0]  DCC_MODE_DEC   = 2'h2;
    localparam logic [1:0]  DCC_ILLEGAL    = 2'h3;
    localparam logic [1:0]  DCC_SZ_8       = 2'h0;
    localparam logic [1:0]  DCC_SZ_16      = 2'h1;
    localparam logic [3:0]  DCC_STEP_IND   = 4'h4;

    typedef enum logic [1:0] {DCC_ST_IDLE, DCC_ST_RD, DCC_ST_WR} dcc_state_t;
endpackage

// ===== src/dcc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module dcc_sync
    import dcc_pkg::*;
#(
    parameter int          W       = 1,
    parameter logic [31:0] RST_VAL = 32'h0000_0000
)
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    initial
    begin
        if (W < 1 || W > 32)
            $error("dcc_sync width out of range");
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_r <= RST_VAL[W-1:0];
            s2_r <= RST_VAL[W-1:0];
            s3_r <= RST_VAL[W-1:0];
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Only stages two and three vote, so a glitch must last two cycles
    genvar i;
    for (i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
                q[i] <= RST_VAL[i];
            else if (s2_r[i] == s3_r[i])
                q[i] <= s3_r[i];
        end
    end
endmodule
`default_nettype wire

// ===== src/dcc_chan_reg.sv
// Per-channel control register with channel-specific bit masks
`timescale 1ns/10ps
`default_nettype none
module dcc_chan_reg
    import dcc_pkg::*;
#(
    parameter int CH = 0
)
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clear,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [31:0] wdata,
    input  wire logic        te_set,
    output logic      [31:0] ctrl
);
    // Unimplemented bits never store, so they read zero
    localparam logic [31:0] MASK = (CH < 2)  ? (DCC_MASK_ALL | DCC_MASK_CH01) :
                                   (CH == 2) ? (DCC_MASK_ALL | DCC_MASK_CH2) :
                                               (DCC_MASK_ALL | DCC_MASK_CH3);
    localparam logic [31:0] WMASK = MASK & ~(32'h1 << DCC_B_TE);

    logic te_seen_r;

    initial
    begin
        if (CH < 0 || CH >= DCC_NCH)
            $error("dcc_chan_reg channel out of range");
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ctrl <= DCC_CTRL_RST;
        else if (clear)
            ctrl <= DCC_CTRL_RST;
        else
        begin
            if (wr)
                ctrl <= (wdata & WMASK) | (ctrl & (32'h1 << DCC_B_TE));
            // Hardware set wins over a same-cycle software clear
            if (te_set)
                ctrl[DCC_B_TE] <= 1'b1;
            else if (wr && !wdata[DCC_B_TE] && te_seen_r)
                ctrl[DCC_B_TE] <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            te_seen_r <= 1'b0;
        else if (clear || !ctrl[DCC_B_TE])
            te_seen_r <= 1'b0;
        else if (rd)
            te_seen_r <= 1'b1;
    end
endmodule
`default_nettype wire

// ===== testbench/dcc_requester.sv
// External requester model driving one request pin
`timescale 1ns/10ps
`default_nettype none
module dcc_requester
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic go,
    input  wire logic ack,
    output logic      req_b
);
    // Level request held until the active-low acknowledge pulse
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            req_b <= 1'b1;
        else if (go)
            req_b <= 1'b0;
        else if (ack == 1'b0)
            req_b <= 1'b1;
    end
endmodule
`default_nettype wire

// ===== testbench/dcc_tb_top.sv
// Self-checking bench for the DMA count and control block
`timescale 1ns/10ps
`default_nettype none
module dcc_tb_top
    import dcc_pkg::*;
;
    logic        clk, rst_b, reg_wr, reg_rd, nmi_in, standby_in, go, xfer_rd, xfer_wr;
    logic        src_indirect, src_reload, reload_seen = 1'b0;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, r, m;
    logic [1:0]  req_b, rak, tak, xfer_size, xfer_chan;
    logic [3:0]  periph_req, end_irq, src_step, dst_step;
    int          num_errors, n_compared, units = 0, i;

    dcc_top uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .transfer_request_in_b(req_b), .periph_req(periph_req), .nmi_in(nmi_in),
        .standby_in(standby_in), .request_acknowledge_out(rak),
        .transfer_acknowledge_out(tak), .end_irq(end_irq), .xfer_rd(xfer_rd),
        .xfer_wr(xfer_wr), .xfer_chan(xfer_chan), .xfer_size(xfer_size),
        .src_step(src_step), .dst_step(dst_step), .src_indirect(src_indirect),
        .src_reload(src_reload));
    dcc_requester peer (.clk(clk), .rst_b(rst_b), .go(go), .ack(rak[1]), .req_b(req_b[1]));
    assign req_b[0] = 1'b1;

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (xfer_wr === 1'b1)
            units <= units + 1;
        if (src_reload === 1'b1)
            reload_seen <= 1'b1;
    end

    task automatic complete_run();
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    // One unit on channel b[5:4]; ak holds expected ack levels in the read cycle
    task automatic run(input logic [7:0] b, input logic [31:0] c, input logic [1:0] sz,
                       input logic [3:0] ss, input logic [3:0] ds, input logic [3:0] ak);
        int k;
        wr(b + 8'h04, 32'h1);
        wr(b, c);
        go <= (b == 8'h10);
        @(posedge clk);
        go <= 1'b0;
        // State flops update after this edge; look once they have settled
        #1;
        k = 0;
        while (xfer_rd !== 1'b1 && k < 60)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        chk({xfer_chan, xfer_size, src_step, dst_step, src_indirect},
            {b[5:4], sz, ss, ds, b == 8'h30});
        chk({rak, tak}, ak);
        repeat (6) @(posedge clk);
        rd(b + 8'h04, 32'h0);
        rd(b, c | 32'h2);
        chk(end_irq[b[5:4]], c[2]);
        wr(b, 32'h0);
    endtask

    initial
    begin
        {rst_b, reg_wr, reg_rd, nmi_in, standby_in, go} = '0;
        {reg_addr, reg_wdata, num_errors, n_compared} = '0;
        void'($urandom(32'h9381));
        periph_req = 4'($urandom);
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            m = (DCC_MASK_ALL & ~32'h2)
                | (i < 2 ? DCC_MASK_CH01 : i == 2 ? DCC_MASK_CH2 : DCC_MASK_CH3);
            rd(8'(16 * i), 32'h0);
            r = $urandom;
            wr(8'(16 * i), r);
            rd(8'(16 * i), r & m);
            r = $urandom;
            wr(8'(16 * i + 4), r);
            rd(8'(16 * i + 4), r & 32'h00ff_ffff);
        end
        rd(8'h48, 32'h0);
        standby_in <= 1'b1;
        repeat (8) @(posedge clk);
        standby_in <= 1'b0;
        repeat (8) @(posedge clk);
        for (i = 0; i < 5; i++)
            rd(8'(16 * i), 32'h0);
        wr(DCC_GLOBAL_OFS, 32'h1);
        run(8'h00, 32'h0005_9415, 2'h2, 4'h4, 4'hc, 4'hf);
        run(8'h10, 32'h0000_0005, 2'h0, 4'h0, 4'h0, 4'h5);
        run(8'h30, 32'h0010_2401, 2'h0, 4'hc, 4'h0, 4'hf);
        for (i = 0; i < 3; i++)
            run(8'h20, 32'h0008_6401 | (i << 3), 2'(i), 4'(-(1 << i)), 4'(1 << i), 4'hf);
        chk(reload_seen, 1'b1);
        periph_req <= periph_req | 4'h4;
        run(8'h20, 32'h0000_0a01, 2'h0, 4'h0, 4'h0, 4'hf);
        run(8'h10, 32'h0000_0045, 2'h0, 4'h0, 4'h0, 4'h5);
        nmi_in <= 1'b1;
        repeat (8) @(posedge clk);
        rd(DCC_GLOBAL_OFS, 32'h3);
        i = units;
        wr(8'h34, 32'h1);
        wr(8'h30, 32'h0000_0401);
        repeat (12) @(posedge clk);
        chk(units, i);
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
